//--- logic/afe_command_sequencer.sv
// Front-end command sequencer: fetch, decode, timers, count and checksum
// Functional notes
// - runs while run bit set, stops on zero
// - only one stored sequence executes at once
// - in-order fetch, no branches, never reads registers
// - stall post-write delay cycles after each write
// - no post-write delay after timer commands
// - pause bit freezes all sequencer activity except a command already in execute
// - host register reads unaffected while paused
// - count each executed command; host write clears
// - CRC-8 x8+x2+x+1 per command, one cycle
// - checksum seeds 0x01 at reset and count write
// - command MSB one means register write
// - seven-bit address gives offset bits 8:2
// - 24 data bits write bits 23:0, bits 31:24 written as zero
// - full 32-bit single-cycle write-only access
// - wait loads counter, resumes at zero
// - separate wait and free-running timeout counters
// - timeout gives done, or error if unfinished
// - timeout flags stick until host clears them
// - live timeout counter always visible to host
// - timeout keeps counting; cleared by host write of run zero
// - timers count clock periods, about 67.1 s
// - descriptor start bits 10:0, count bits 26:16
// - request while busy ignored and reported
// - sequencer write beats same-cycle host write
// - end interrupt only when command clears run
`timescale 1ns/10ps
`include "afe_seq_defs.svh"

module afe_command_sequencer
  import afe_seq_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  host_ctrl_wr_in,
  input  wire seq_ctrl_t             host_ctrl_data_in,
  input  wire seq_desc_t [3:0]       sequence_descriptor_in,
  input  wire logic [3:0]            seq_request_in,
  input  wire logic                  counter_clear_in,
  input  wire logic [3:0]            irq_clear_in,
  input  wire logic [31:0]           cmd_data_in,
  input  wire afe_wr_t               host_wr_in,
  output logic                       cmd_rd_out,
  output logic [10:0]                cmd_addr_out,
  output afe_wr_t                    afe_wr_out,
  output seq_ctrl_t                  sequencer_control_out,
  output logic [CNT_W-1:0]           executed_command_counter_out,
  output logic [7:0]                 command_checksum_out,
  output logic [`TMO_W-1:0]          timeout_counter_value_out,
  output logic                       busy_out,
  output logic [3:0]                 irq_flags_out
);

  // ========================================================================
  // State and decode
  seq_state_t          state;
  seq_ctrl_t           ctrl;
  logic [10:0]         remaining;
  logic [`TMO_W-1:0]   wait_cnt;
  logic                tmo_active;
  logic                paused;
  logic                run;
  logic                exec;
  logic                is_write;
  logic                is_tmo;
  logic                is_wait;
  logic [`TMO_W-1:0]   cmd_count;
  logic [8:0]          cmd_offset;
  logic                seq_ctrl_wr;
  logic                end_seq;
  logic                host_stop;
  logic                tmo_expire;
  logic                start;
  logic [1:0]          start_sel;
  logic                ignored;

  assign paused     = ctrl.pause_bit;
  assign run        = ctrl.run_enable_bit;
  assign exec       = (state == ST_EXEC);
  assign is_write   = exec && cmd_data_in[`CMD_WRITE_BIT];
  assign is_tmo     = exec && !cmd_data_in[`CMD_WRITE_BIT]
                      && cmd_data_in[`CMD_TMO_BIT];
  assign is_wait    = exec && !cmd_data_in[`CMD_WRITE_BIT]
                      && !cmd_data_in[`CMD_TMO_BIT];
  assign cmd_count  = cmd_data_in[`CMD_COUNT_MSB:0];
  assign cmd_offset = {cmd_data_in[`CMD_ADDR_MSB:`CMD_ADDR_LSB], 2'b00};
  assign seq_ctrl_wr = is_write && (cmd_offset == `AFE_CTRL_OFFSET);
  assign end_seq    = seq_ctrl_wr && !cmd_data_in[`CTRL_RUN_BIT];
  assign host_stop  = host_ctrl_wr_in && !seq_ctrl_wr
                      && !host_ctrl_data_in.run_enable_bit;
  assign busy_out   = (state != ST_IDLE);
  assign start      = run && !paused && !busy_out && (|seq_request_in);
  assign ignored    = busy_out && (|seq_request_in);
  assign tmo_expire = tmo_active && !paused
                      && (timeout_counter_value_out <= `TMO_W'(1));

  // Lowest requested sequence wins when several arrive together
  always_comb begin
    start_sel = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (seq_request_in[i]) begin
        start_sel = 2'(i);
      end
    end
  end

  // Read strobe to command memory; data returns on the next edge
  assign cmd_rd_out = (state == ST_FETCH) && run && !paused
                      && (remaining != 11'd0);

  // ========================================================================
  // Control register: sequencer write takes priority over host write
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl <= `CTRL_RESET;
    end else if (seq_ctrl_wr) begin
      ctrl <= seq_ctrl_t'(cmd_data_in[15:0]);
    end else if (host_ctrl_wr_in) begin
      ctrl <= host_ctrl_data_in;
    end
  end
  assign sequencer_control_out = ctrl;

  // ========================================================================
  // Sequence flow: one sequence at a time, strictly in order
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state        <= ST_IDLE;
      remaining    <= 11'd0;
      cmd_addr_out <= 11'd0;
    end else if (!run) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            cmd_addr_out <= sequence_descriptor_in[start_sel].start_addr;
            remaining    <= sequence_descriptor_in[start_sel].cmd_count;
            state        <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (!paused) begin
            if (remaining == 11'd0) begin
              state <= ST_IDLE;
            end else begin
              cmd_addr_out <= cmd_addr_out + 11'd1;
              remaining    <= remaining - 11'd1;
              state        <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (end_seq) begin
            state <= ST_IDLE;
          end else if (is_write && ctrl.post_write_delay != 8'd0) begin
            state <= ST_STALL;
          end else if (is_wait && cmd_count != `TMO_W'(0)) begin
            state <= ST_STALL;
          end else begin
            state <= ST_FETCH;
          end
        end
        ST_STALL: begin
          if (!paused && wait_cnt <= `TMO_W'(1)) begin
            state <= ST_FETCH;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Wait counter, shared by wait commands and post-write delay
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wait_cnt <= `TMO_W'(0);
    end else if (is_write) begin
      wait_cnt <= `TMO_W'(ctrl.post_write_delay);
    end else if (is_wait) begin
      wait_cnt <= cmd_count;
    end else if (state == ST_STALL && !paused
                 && wait_cnt != `TMO_W'(0)) begin
      wait_cnt <= wait_cnt - `TMO_W'(1);
    end
  end

  // ========================================================================
  // Timeout counter, free-running once loaded
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      timeout_counter_value_out <= `TMO_W'(0);
      tmo_active                <= 1'b0;
    end else if (host_stop) begin
      timeout_counter_value_out <= `TMO_W'(0);
      tmo_active                <= 1'b0;
    end else if (is_tmo) begin
      timeout_counter_value_out <= cmd_count;
      tmo_active                <= 1'b1;
    end else if (tmo_expire) begin
      timeout_counter_value_out <= `TMO_W'(0);
      tmo_active                <= 1'b0;
    end else if (tmo_active && !paused) begin
      timeout_counter_value_out <= timeout_counter_value_out
                                   - `TMO_W'(1);
    end
  end

  // ========================================================================
  // Executed-command count and checksum
  function automatic logic [7:0] crc8_word(input logic [7:0]  crc,
                                           input logic [31:0] word);
    logic [7:0] c;
    c = crc;
    for (int b = 31; b >= 0; b--) begin
      if (c[7] ^ word[b]) begin
        c = {c[6:0], 1'b0} ^ `CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rstn_in || counter_clear_in) begin
      executed_command_counter_out <= CNT_W'(`CMD_CNT_RESET);
      command_checksum_out         <= `CRC_SEED;
    end else if (exec) begin
      executed_command_counter_out <= executed_command_counter_out
                                      + CNT_W'(1);
      command_checksum_out <= crc8_word(command_checksum_out,
                                        cmd_data_in);
    end
  end

  // ========================================================================
  // Front-end write port; host reads never pass through here
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      afe_wr_out <= '0;
    end else if (is_write) begin
      afe_wr_out.en   <= 1'b1;
      afe_wr_out.addr <= cmd_offset;
      afe_wr_out.data <= {8'h00,
                          cmd_data_in[`CMD_DATA_MSB:0]};
    end else begin
      afe_wr_out <= host_wr_in;
    end
  end

  // ========================================================================
  // Sticky event flags: 0 done, 1 error, 2 end, 3 ignored
  logic [3:0] irq_set;
  assign irq_set = {ignored, end_seq,
                    tmo_expire && busy_out,
                    tmo_expire && !busy_out};

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_flags_out <= 4'h0;
    end else begin
      irq_flags_out <= irq_set | (irq_flags_out & ~irq_clear_in);
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  write_delay_a: assert property (
    (is_write && !end_seq && ctrl.post_write_delay == 8'd3 && !paused)
    ##1 !paused [*3] |=> state == ST_FETCH && $past(state, 3) == ST_STALL)
    else $error("post-write delay length wrong");

  timer_nodelay_a: assert property (
    (is_tmo && run) |=> state == ST_FETCH)
    else $error("delay applied after timeout command");

  pause_hold_a: assert property (
    (paused && state == ST_STALL && !is_write && !is_wait)
    |=> wait_cnt == $past(wait_cnt) && state == ST_STALL)
    else $error("stall advanced while paused");

  count_step_a: assert property (
    (exec && !counter_clear_in) |=> executed_command_counter_out
      == $past(executed_command_counter_out) + CNT_W'(1))
    else $error("command count did not step by one");

  crc_seed_a: assert property (
    counter_clear_in |=> command_checksum_out == `CRC_SEED)
    else $error("checksum not reseeded");

  write_format_a: assert property (
    is_write |=> afe_wr_out.en && afe_wr_out.data[31:24] == 8'h00
      && afe_wr_out.addr[1:0] == 2'b00)
    else $error("bad front-end write format");

  host_drop_a: assert property (
    (is_write && host_wr_in.en) |=> afe_wr_out.addr == $past(cmd_offset))
    else $error("host write not dropped");

  ignore_flag_a: assert property (
    ignored |=> irq_flags_out[3] && remaining <= $past(remaining))
    else $error("ignored request not reported");

  tmo_error_a: assert property (
    (tmo_expire && busy_out && !is_tmo && !host_stop) |=> irq_flags_out[1]
      && timeout_counter_value_out == `TMO_W'(0))
    else $error("timeout error flag missing");

  run_stop_a: assert property (
    host_stop |=> (timeout_counter_value_out == `TMO_W'(0) && !tmo_active)
    ##1 state == ST_IDLE)
    else $error("host stop did not clear timeout");

endmodule // afe_command_sequencer

//--- logic/afe_seq_defs.svh
// Offsets, field positions, reset values and timing figures of the sequencer
`ifndef AFE_SEQ_DEFS_SVH
`define AFE_SEQ_DEFS_SVH

// ==========================================================================
// Command word fields
`define CMD_WRITE_BIT     31
`define CMD_TMO_BIT       30
`define CMD_ADDR_MSB      30
`define CMD_ADDR_LSB      24
`define CMD_DATA_MSB      23
`define CMD_COUNT_MSB     29

// ==========================================================================
// Front-end register offsets and widths
`define AFE_OFFSET_W      9
`define AFE_CTRL_OFFSET   9'h004
`define CTRL_RUN_BIT      0
`define CTRL_RESET        16'h0000

// ==========================================================================
// Checksum and counter reset values
`define CRC_SEED          8'h01
`define CRC_POLY          8'h07
`define CMD_CNT_RESET     16'h0000

// ==========================================================================
// Timer figures
`define ACLK_HZ           16000000
`define MAX_TIMEOUT_MS    67100
`define TMO_W             30

`endif

//--- logic/afe_seq_pkg.sv
// Types shared by the command sequencer and its users
package afe_seq_pkg;

  // ========================================================================
  // Control word: run, pause and post-write delay
  typedef struct packed {
    logic [7:0] post_write_delay;
    logic [5:0] reserved;
    logic       pause_bit;
    logic       run_enable_bit;
  } seq_ctrl_t;

  // ========================================================================
  // Sequence descriptor: command count and start address
  typedef struct packed {
    logic [4:0]  reserved_hi;
    logic [10:0] cmd_count;
    logic [4:0]  reserved_lo;
    logic [10:0] start_addr;
  } seq_desc_t;

  // ========================================================================
  // Front-end register write
  typedef struct packed {
    logic        en;
    logic [8:0]  addr;
    logic [31:0] data;
  } afe_wr_t;

  // ========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10,
    ST_STALL = 2'b11
  } seq_state_t;

endpackage : afe_seq_pkg

//--- tb/cmd_mem_model.sv
// Command memory model answering the sequencer's fetches
`timescale 1ns/10ps

module cmd_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic [10:0] addr_in,
  output logic      [31:0] data_out
);
  // ==========================================================
  // Storage, loaded by the bench
  logic [31:0] mem [0:2047];

  initial data_out = 32'h00000000;

  // ==========================================================
  // Read data one cycle after the strobe, churned otherwise
  always @(posedge clk_in) begin
    if (rd_in) begin
      data_out <= mem[addr_in];
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule // cmd_mem_model

//--- tb/tb_top.sv
// Self-checking bench for the front-end command sequencer
`timescale 1ns/10ps
`include "afe_seq_defs.svh"

module tb_top
  import afe_seq_pkg::*;
;
  logic              clk_in;
  logic              rstn_in;
  logic              host_ctrl_wr_in;
  seq_ctrl_t         host_ctrl_data_in;
  seq_desc_t [3:0]   sequence_descriptor_in;
  logic [3:0]        seq_request_in;
  logic              counter_clear_in;
  logic [3:0]        irq_clear_in;
  logic [31:0]       cmd_data_in;
  afe_wr_t           host_wr_in;
  logic              cmd_rd_out;
  logic [10:0]       cmd_addr_out;
  afe_wr_t           afe_wr_out;
  seq_ctrl_t         sequencer_control_out;
  logic [15:0]       executed_command_counter_out;
  logic [7:0]        command_checksum_out;
  logic [`TMO_W-1:0] timeout_counter_value_out;
  logic              busy_out;
  logic [3:0]        irq_flags_out;
  int                fail_count;
  int                n_compared;
  int                cyc;
  int                n;
  int                rd_cyc[$];
  logic [10:0]       rd_adr[$];
  afe_wr_t           wr_q[$];
  logic [`TMO_W-1:0] tv;

  afe_command_sequencer u_afe_command_sequencer (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .host_ctrl_wr_in(host_ctrl_wr_in),
    .host_ctrl_data_in(host_ctrl_data_in),
    .sequence_descriptor_in(sequence_descriptor_in),
    .seq_request_in(seq_request_in),
    .counter_clear_in(counter_clear_in), .irq_clear_in(irq_clear_in),
    .cmd_data_in(cmd_data_in), .host_wr_in(host_wr_in),
    .cmd_rd_out(cmd_rd_out), .cmd_addr_out(cmd_addr_out),
    .afe_wr_out(afe_wr_out),
    .sequencer_control_out(sequencer_control_out),
    .executed_command_counter_out(executed_command_counter_out),
    .command_checksum_out(command_checksum_out),
    .timeout_counter_value_out(timeout_counter_value_out),
    .busy_out(busy_out), .irq_flags_out(irq_flags_out)
  );

  cmd_mem_model u_cmd_mem_model (
    .clk_in(clk_in), .rd_in(cmd_rd_out), .addr_in(cmd_addr_out),
    .data_out(cmd_data_in)
  );

  // ==========================================================
  // Clock and fetch/write monitor
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cmd_rd_out === 1'b1) begin
      rd_cyc.push_back(cyc);
      rd_adr.push_back(cmd_addr_out);
    end
    if (afe_wr_out.en === 1'b1 && afe_wr_out.addr !== 9'h010) begin
      wr_q.push_back(afe_wr_out);
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ w[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic check(input string what, input logic [41:0] exp,
                       input logic [41:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d compared, %0d mismatched", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic ctrl(input logic run, input logic pause,
                      input logic [7:0] d);
    host_ctrl_data_in = {d, 6'h00, pause, run};
    host_ctrl_wr_in = 1'b1;
    tick(1);
    host_ctrl_wr_in = 1'b0;
  endtask

  task automatic pulse_req(input logic [3:0] r);
    seq_request_in = r;
    tick(1);
    seq_request_in = 4'h0;
  endtask

  task automatic clear_flags();
    irq_clear_in = 4'hF;
    tick(1);
    irq_clear_in = 4'h0;
    tick(1);
    check("flags_cleared", 42'h0, 42'(irq_flags_out));
  endtask

  task automatic wait_until(input bit flag0, input int lim);
    int k;
    k = 0;
    while (k < lim && !(flag0 ? irq_flags_out[0] === 1'b1
                              : busy_out === 1'b0)) begin
      tick(1);
      k++;
    end
    if (k >= lim) begin
      fail_count++;
      $display("ERROR wait expected done seen pending");
      end_sim();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    cyc = 0;
    rstn_in = 1'b0;
    host_ctrl_wr_in = 1'b0;
    host_ctrl_data_in = '0;
    seq_request_in = 4'h0;
    counter_clear_in = 1'b0;
    irq_clear_in = 4'h0;
    host_wr_in = '0;
    sequence_descriptor_in[0] = {5'h00, 11'h004, 5'h00, 11'h000};
    sequence_descriptor_in[1] = {5'h00, 11'h003, 5'h00, 11'h010};
    sequence_descriptor_in[2] = {5'h00, 11'h001, 5'h00, 11'h020};
    sequence_descriptor_in[3] = {5'h00, 11'h001, 5'h00, 11'h030};
    u_cmd_mem_model.mem[0] = 32'h85A5A5A5;
    u_cmd_mem_model.mem[1] = 32'hFFFFFFFF;
    u_cmd_mem_model.mem[2] = 32'h00000005;
    u_cmd_mem_model.mem[3] = 32'h80000001;
    u_cmd_mem_model.mem[16] = 32'h40000014;
    u_cmd_mem_model.mem[17] = 32'h00000028;
    u_cmd_mem_model.mem[18] = 32'h81000000;
    u_cmd_mem_model.mem[32] = 32'h4000001E;
    u_cmd_mem_model.mem[48] = 32'h00000001;
    tick(5);
    rstn_in = 1'b1;
    tick(1);
    check("checksum", 42'h01, 42'(command_checksum_out));
    check("count", 42'h0, 42'(executed_command_counter_out));
    check("flags_busy", 42'h0, 42'({irq_flags_out, busy_out}));
    $display("Test reset done");

    host_wr_in = {1'b1, 9'h010, 32'h12345678};
    tick(1);
    check("host_wr", 42'(host_wr_in), 42'(afe_wr_out));
    ctrl(1'b1, 1'b0, 8'h03);
    pulse_req(4'h1);
    check("busy", 42'h1, 42'(busy_out));
    wait_until(1'b0, 200);
    host_wr_in = '0;
    check("wr_n", 42'h3, 42'(wr_q.size()));
    check("wr0", {1'b1, 9'h014, 32'h00A5A5A5}, wr_q[0]);
    check("wr1", {1'b1, 9'h1FC, 32'h00FFFFFF}, wr_q[1]);
    check("wr2", {1'b1, 9'h000, 32'h00000001}, wr_q[2]);
    check("gap0", 42'h5, 42'(rd_cyc[1] - rd_cyc[0]));
    check("gap1", 42'h5, 42'(rd_cyc[2] - rd_cyc[1]));
    check("gap2", 42'h7, 42'(rd_cyc[3] - rd_cyc[2]));
    check("count", 42'h4, 42'(executed_command_counter_out));
    check("checksum", 42'(crc8(crc8(crc8(crc8(8'h01, 32'h85A5A5A5),
      32'hFFFFFFFF), 32'h00000005), 32'h80000001)),
      42'(command_checksum_out));
    counter_clear_in = 1'b1;
    tick(1);
    counter_clear_in = 1'b0;
    check("count_clr", 42'h0, 42'(executed_command_counter_out));
    check("crc_seed", 42'h01, 42'(command_checksum_out));
    $display("Test write sequence done");

    rd_cyc.delete();
    rd_adr.delete();
    pulse_req(4'h6);
    tick(1);
    pulse_req(4'h1);
    ctrl(1'b1, 1'b1, 8'h03);
    tick(1);
    tv = timeout_counter_value_out;
    n = rd_cyc.size();
    tick(8);
    check("paused_tmo", 42'(tv), 42'(timeout_counter_value_out));
    check("paused_rd", 42'(n), 42'(rd_cyc.size()));
    ctrl(1'b1, 1'b0, 8'h03);
    wait_until(1'b0, 300);
    check("first_addr", 42'h010, 42'(rd_adr[0]));
    check("tmo_gap", 42'h2, 42'(rd_cyc[1] - rd_cyc[0]));
    check("flags", 42'hE, 42'(irq_flags_out));
    check("run", 42'h0, 42'(sequencer_control_out.run_enable_bit));
    tick(5);
    check("sticky", 42'hE, 42'(irq_flags_out));
    clear_flags();
    $display("Test timeout error done");

    ctrl(1'b1, 1'b0, 8'h00);
    pulse_req(4'h4);
    wait_until(1'b0, 50);
    tv = timeout_counter_value_out;
    tick(2);
    check("tmo_live", 42'(tv - 30'h2),
      42'(timeout_counter_value_out));
    wait_until(1'b1, 60);
    check("flags", 42'h1, 42'(irq_flags_out));
    clear_flags();
    $display("Test timeout done finished");

    pulse_req(4'h4);
    wait_until(1'b0, 50);
    ctrl(1'b0, 1'b0, 8'h00);
    check("tmo_clr", 42'h0, 42'(timeout_counter_value_out));
    tick(40);
    check("no_flags", 42'h0, 42'(irq_flags_out));
    $display("Test abort done");
    end_sim();
  end
endmodule // tb_top
